/* inc/ddr_ctrl_regs.svh */
// Register offsets, field positions, reset values and timing constants.
`ifndef DDR_CTRL_REGS_SVH
`define DDR_CTRL_REGS_SVH

// ==========================================================================
// Register byte offsets on the Avalon-MM slave
`define OFS_CTRL 5'h00
`define OFS_TREFI 5'h04
`define OFS_TRFC 5'h08
`define OFS_TMRP 5'h0C
`define OFS_STATUS 5'h10
`define OFS_MODE 5'h14
`define OFS_GEOM 5'h18

// ==========================================================================
// Field positions
`define CTRL_EN_BIT 0
`define FLD_TREFI 15:0
`define FLD_TRFC 5:0
`define FLD_TMRD 2:0
`define FLD_TRP 6:4
`define ST_DONE_BIT 0
`define ST_BUSY_BIT 1
`define FLD_TALLY 7:4
`define FLD_MR 15:0
`define FLD_EMR 31:16
`define FLD_G_ROW 7:0
`define FLD_G_COL 15:8
`define FLD_G_BANK 23:16
`define FLD_G_DEV 31:24
`define MR_FLD_BL 2:0
`define MR_BT_BIT 3
`define MR_FLD_CL 6:4
`define A10_BIT 10

// ==========================================================================
// Reset values and encodings
`define CTRL_RST 1'h1
`define TREFI_RST 16'h061B
`define TRFC_RST_DDR 6'h0E
`define TRFC_RST_DDR2 6'h15
`define TMRD_RST 3'h2
`define TRP_RST 3'h3
`define BL2_CODE 3'h1
`define BL4_CODE 3'h2
`define BL8_CODE 3'h3
`define PINS_NOP 3'h7
`define PINS_PREA 3'h2
`define PINS_LMR 3'h0
`define PINS_REF 3'h1
`define BA_MR 3'h0
`define BA_EMR 3'h1
`define INIT_REF_N 4'h2
`define TALLY_MAX 4'hF

// ==========================================================================
// Timing: controller clock is clk_sys / 2
`define CLK_PS 5000
`define MCK_PS (`CLK_PS * 2)
`define PREA_MIN_NS 400
`define PREA_MIN_CYC ((`PREA_MIN_NS * 1000 + `MCK_PS - 1) / `MCK_PS)
`define TCKP_DEF 107

`endif

/* inc/ddr_ctrl_pkg.sv */
// Types shared by the controller sequencer and its wait timer.
package ddr_ctrl_pkg;

   // ========================================================================
   // Sequencer states and memory commands
   typedef enum logic [2:0] {S_RST, S_PREA, S_EMR, S_MRS, S_IREF, S_IDLE,
      S_REF} st_t;
   typedef enum logic [1:0] {C_NOP, C_PREA, C_LMR, C_REF} cmd_t;

   // ========================================================================
   // Complete state of the sequencer
   typedef struct packed {
      st_t st;
      logic [3:0] rcnt;
      logic [3:0] tally;
      logic [15:0] refi;
      logic ph;
      logic ck;
      logic cke;
      logic cs_n;
      logic [2:0] pins;
      logic [2:0] ba;
      logic [15:0] addr;
      logic [1:0] odt;
      logic done;
      logic en;
      logic [15:0] trefi;
      logic [5:0] trfc;
      logic [2:0] tmrd;
      logic [2:0] trp;
      logic wreq;
      logic [31:0] rdata;
      logic c1;
      logic c2;
      logic c3;
      logic r1;
      logic r2;
      logic ext;
   } ctl_t;

endpackage : ddr_ctrl_pkg

/* inc/ddr_tmr_if.sv */
// Handshake between the sequencer and its command spacing timer.
`timescale 1ns/1ps
interface ddr_tmr_if;
   logic tick;
   logic load;
   logic [15:0] value;
   logic done;
   modport ctl (output tick, output load, output value, input done);
   modport tmr (input tick, input load, input value, output done);
endinterface : ddr_tmr_if

/* logic/ddr_wait_timer.sv */
// Down counter that spaces memory commands by a loaded cycle count.
`timescale 1ns/1ps
module ddr_wait_timer
   import ddr_ctrl_pkg::*;
   #(parameter int W = 16)
   (
   input wire logic clk_sys,
   input wire logic rst_b,
   ddr_tmr_if.tmr tif
   );

   typedef struct packed {logic [W-1:0] cnt;} tmr_t;
   tmr_t s_q;
   tmr_t s_d;

   if (W < 7 || W > 16) begin : g_bad
      $error("Timer width must be 7 to 16 bits.");
   end

   // ========================================================================
   // Counting
   // A load of N ends the wait N controller cycles after the command.
   always_comb
   begin
      s_d = s_q;
      if (tif.tick)
      begin
         if (tif.load)
            s_d.cnt = W'(tif.value - 16'h1);
         else if (s_q.cnt != '0)
            s_d.cnt = W'(s_q.cnt - 1'b1);
      end
   end

   // State register.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // Done is a level while the count stands at zero.
   assign tif.done = (s_q.cnt == '0);

   // ========================================================================
   // Checks
   property p_load_holds;
      @(posedge clk_sys) disable iff (!rst_b)
      tif.tick && tif.load && tif.value > 16'h1 |=> (!tif.done) [*2];
   endproperty
   a_load_holds: assert property (p_load_holds)
      else $error("Timer ended a wait too early.");

endmodule : ddr_wait_timer

/* logic/ddr_init_refresh.sv */
// DDR/DDR2 initialization and refresh sequencer with an Avalon-MM slave.
`timescale 1ns/1ps
`include "ddr_ctrl_regs.svh"
module ddr_init_refresh
   import ddr_ctrl_pkg::*;
   #(
   parameter int DDR2 = 0,
   parameter int ROW_W = 13,
   parameter int COL_W = 10,
   parameter int BANKS = 4,
   parameter int DEV_W = 8,
   parameter int CS_W = 1,
   parameter int CK_W = 1,
   parameter int CKE_W = 1,
   parameter int SLOTS = 1,
   parameter int WR_DATA_DELAY = 1,
   parameter int FIXED_TIMING = 0,
   parameter int INIT_EXT_MODE_PROGRAM_ENABLE = 1,
   parameter int REF_BURST = 8,
   parameter int EXT_REF = 0,
   parameter int BURST_LEN = 4,
   parameter int CAS_LAT = 2,
   parameter int BURST_ILV = 0,
   parameter logic [15:0] EXTENDED_MODE_REGISTER = 16'h0000,
   parameter logic [6:0] TCKP = 7'(`TCKP_DEF),
   localparam int BA_W = (BANKS == 8) ? 3 : 2
   )
   (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ext_ref_clk,
   input wire logic ext_ref_req,
   output logic [CK_W-1:0] mem_ck,
   output logic [CKE_W-1:0] mem_cke,
   output logic [CS_W-1:0] mem_cs_n,
   output logic mem_ras_n,
   output logic mem_cas_n,
   output logic mem_we_n,
   output logic [BA_W-1:0] mem_ba,
   output logic [ROW_W-1:0] mem_addr,
   output logic [SLOTS-1:0] mem_odt,
   output logic init_done
   );

   // ========================================================================
   // Configuration checks
   // Geometry, select count, slots and mode values are refused if the
   // sequencer cannot serve them; DDR has only four banks.
   if (ROW_W < 13 || ROW_W > 16 || COL_W < 9 || COL_W > 11 ||
       !(BANKS == 4 || (BANKS == 8 && DDR2 != 0)) ||
       !(DEV_W == 4 || DEV_W == 8 || DEV_W == 16) ||
       CS_W < 1 || CS_W > ((DDR2 != 0) ? 4 : 8) ||
       CK_W < 1 || CK_W > 2 || CKE_W < 1 || CKE_W > 2 ||
       SLOTS < 1 || SLOTS > 2 || WR_DATA_DELAY < 1 || WR_DATA_DELAY > 2 ||
       REF_BURST < 2 || REF_BURST > 8 ||
       !(BURST_LEN == 4 || BURST_LEN == 8 || (BURST_LEN == 2 && DDR2 == 0))
       || CAS_LAT < 2 || CAS_LAT > ((DDR2 != 0) ? 6 : 3) ||
       int'(TCKP) < `PREA_MIN_CYC) begin : g_bad
      $error("Unsupported controller configuration.");
   end

   // Mode word written at initialization.
   function automatic logic [15:0] mode_word();
      logic [15:0] w;
      w = '0;
      w[`MR_FLD_BL] = (BURST_LEN == 2) ? `BL2_CODE :
         (BURST_LEN == 4) ? `BL4_CODE : `BL8_CODE;
      w[`MR_BT_BIT] = (BURST_ILV != 0);
      w[`MR_FLD_CL] = 3'(CAS_LAT);
      return w;
   endfunction : mode_word

   // Pin pattern of RAS, CAS and WE for each command.
   function automatic logic [2:0] pins_of(input cmd_t c);
      case (c)
         C_PREA: return `PINS_PREA;
         C_LMR: return `PINS_LMR;
         C_REF: return `PINS_REF;
         default: return `PINS_NOP;
      endcase
   endfunction : pins_of

   // Merges written bytes into the current register word.
   function automatic logic [31:0] bmerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction : bmerge

   localparam logic [15:0] MODE_WORD = mode_word();
   localparam logic DO_EMR = (DDR2 != 0) || (INIT_EXT_MODE_PROGRAM_ENABLE != 0);
   localparam logic [1:0] ODT_MASK = (DDR2 == 0) ? 2'h0 :
      (SLOTS == 2) ? 2'h3 : 2'h1;

   ctl_t s_q;
   ctl_t s_d;
   ddr_tmr_if tif ();

   // ========================================================================
   // Next-state logic
   always_comb
   begin
      logic [31:0] rd;
      logic [31:0] w;
      logic exp;
      logic start;
      logic rise;
      rd = '0;
      w = '0;
      exp = 1'b0;
      start = 1'b0;
      rise = 1'b0;
      s_d = s_q;
      tif.load = 1'b0;
      tif.value = '0;
      tif.tick = s_q.ph;

      // Memory clock and the controller clock enable, both clk_sys / 2.
      s_d.ph = ~s_q.ph;
      s_d.ck = ~s_q.ck;

      // Two-stage synchronisers for the external refresh link.
      s_d.c1 = ext_ref_clk;
      s_d.c2 = s_q.c1;
      s_d.c3 = s_q.c2;
      s_d.r1 = ext_ref_req;
      s_d.r2 = s_q.r1;
      rise = s_q.c2 && !s_q.c3;

      // Register readback.
      case (avs_address)
         `OFS_CTRL: rd[`CTRL_EN_BIT] = s_q.en;
         `OFS_TREFI: rd[`FLD_TREFI] = s_q.trefi;
         `OFS_TRFC: rd[`FLD_TRFC] = s_q.trfc;
         `OFS_TMRP:
         begin
            rd[`FLD_TMRD] = s_q.tmrd;
            rd[`FLD_TRP] = s_q.trp;
         end
         `OFS_STATUS:
         begin
            rd[`ST_DONE_BIT] = s_q.done;
            rd[`ST_BUSY_BIT] = (s_q.st != S_IDLE);
            rd[`FLD_TALLY] = s_q.tally;
         end
         `OFS_MODE:
         begin
            rd[`FLD_MR] = MODE_WORD;
            rd[`FLD_EMR] = EXTENDED_MODE_REGISTER;
         end
         `OFS_GEOM:
         begin
            rd[`FLD_G_ROW] = 8'(ROW_W);
            rd[`FLD_G_COL] = 8'(COL_W);
            rd[`FLD_G_BANK] = 8'(BANKS);
            rd[`FLD_G_DEV] = 8'(DEV_W);
         end
         default: rd = '0;
      endcase

      // Avalon slave: one wait cycle, then the answer.
      s_d.wreq = 1'b1;
      if ((avs_read || avs_write) && s_q.wreq)
      begin
         s_d.wreq = 1'b0;
         s_d.rdata = rd;
      end
      w = bmerge(rd, avs_writedata, avs_byteenable);
      if (avs_write && !s_q.wreq)
      begin
         case (avs_address)
            `OFS_CTRL: s_d.en = w[`CTRL_EN_BIT];
            `OFS_TREFI:
               if (FIXED_TIMING == 0)
                  s_d.trefi = w[`FLD_TREFI];
            `OFS_TRFC:
               if (FIXED_TIMING == 0)
                  s_d.trfc = w[`FLD_TRFC];
            `OFS_TMRP:
               if (FIXED_TIMING == 0)
               begin
                  s_d.tmrd = w[`FLD_TMRD];
                  s_d.trp = w[`FLD_TRP];
               end
            default: s_d.en = s_q.en;
         endcase
      end

      // Command sequencer, advanced once per controller cycle.
      if (s_q.ph)
      begin
         s_d.cs_n = 1'b1;
         s_d.pins = pins_of(C_NOP);
         s_d.odt = (s_q.st == S_IDLE && s_q.done) ? ODT_MASK : 2'h0;
         // Free-running interval counter; a zero setting means 65536.
         if (s_q.done && EXT_REF == 0)
         begin
            if (s_q.refi == '0)
            begin
               s_d.refi = 16'(s_q.trefi - 16'h1);
               exp = 1'b1;
            end
            else
               s_d.refi = 16'(s_q.refi - 16'h1);
         end
         if (exp && s_q.tally != `TALLY_MAX)
            s_d.tally = 4'(s_q.tally + 4'h1);
         start = s_q.en && ((EXT_REF != 0) ? s_q.ext :
            (s_q.tally >= 4'(REF_BURST)));
         if (tif.done)
         begin
            case (s_q.st)
               S_RST:
               begin
                  s_d.cke = 1'b1;
                  tif.load = 1'b1;
                  tif.value = (DDR2 != 0) ? 16'(TCKP) : 16'h1;
                  s_d.st = S_PREA;
               end
               S_PREA:
               begin
                  s_d.cs_n = 1'b0;
                  s_d.pins = pins_of(C_PREA);
                  s_d.addr = '0;
                  s_d.addr[`A10_BIT] = 1'b1;
                  tif.load = 1'b1;
                  tif.value = 16'(s_q.trp);
                  s_d.st = DO_EMR ? S_EMR : S_MRS;
               end
               S_EMR:
               begin
                  s_d.cs_n = 1'b0;
                  s_d.pins = pins_of(C_LMR);
                  s_d.ba = `BA_EMR;
                  s_d.addr = EXTENDED_MODE_REGISTER;
                  tif.load = 1'b1;
                  tif.value = 16'(s_q.tmrd);
                  s_d.st = S_MRS;
               end
               S_MRS:
               begin
                  s_d.cs_n = 1'b0;
                  s_d.pins = pins_of(C_LMR);
                  s_d.ba = `BA_MR;
                  s_d.addr = MODE_WORD;
                  tif.load = 1'b1;
                  tif.value = 16'(s_q.tmrd);
                  s_d.rcnt = `INIT_REF_N;
                  s_d.st = S_IREF;
               end
               S_IREF, S_REF:
               begin
                  s_d.cs_n = 1'b0;
                  s_d.pins = pins_of(C_REF);
                  tif.load = 1'b1;
                  tif.value = 16'(s_q.trfc);
                  s_d.rcnt = 4'(s_q.rcnt - 4'h1);
                  if (s_q.rcnt == 4'h1)
                  begin
                     s_d.st = S_IDLE;
                     s_d.done = 1'b1;
                     if (s_q.st == S_REF)
                        s_d.tally = exp ? 4'h1 : 4'h0;
                  end
               end
               S_IDLE:
                  if (start)
                  begin
                     s_d.cs_n = 1'b0;
                     s_d.pins = pins_of(C_PREA);
                     s_d.addr = '0;
                     s_d.addr[`A10_BIT] = 1'b1;
                     tif.load = 1'b1;
                     tif.value = 16'(s_q.trp);
                     s_d.rcnt = (EXT_REF != 0) ? 4'h1 : 4'(REF_BURST);
                     s_d.ext = 1'b0;
                     s_d.st = S_REF;
                  end
               default: s_d.st = S_RST;
            endcase
         end
      end

      // A request caught at a link clock edge; the set wins over a clear.
      if (EXT_REF != 0 && rise && s_q.r2)
         s_d.ext = 1'b1;
   end

   // ========================================================================
   // State register
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_q <= '0;
         s_q.cs_n <= 1'b1;
         s_q.pins <= `PINS_NOP;
         s_q.wreq <= 1'b1;
         s_q.en <= `CTRL_RST;
         s_q.trefi <= `TREFI_RST;
         s_q.trfc <= (DDR2 != 0) ? `TRFC_RST_DDR2 : `TRFC_RST_DDR;
         s_q.tmrd <= `TMRD_RST;
         s_q.trp <= `TRP_RST;
      end
      else
         s_q <= s_d;
   end

   ddr_wait_timer #(.W(16)) u_timer (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .tif(tif.tmr)
   );

   // Outputs, each a copy of a register bit.
   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = s_q.wreq;
   assign mem_ck = {CK_W{s_q.ck}};
   assign mem_cke = {CKE_W{s_q.cke}};
   assign mem_cs_n = {CS_W{s_q.cs_n}};
   assign {mem_ras_n, mem_cas_n, mem_we_n} = s_q.pins;
   assign mem_ba = s_q.ba[BA_W-1:0];
   assign mem_addr = s_q.addr[ROW_W-1:0];
   assign mem_odt = s_q.odt[SLOTS-1:0];
   assign init_done = s_q.done;

   // ========================================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   logic [7:0] mck_n;
   logic [7:0] gap;
   logic last_ref;
   wire cmd = !s_q.cs_n;
   wire lmr = cmd && s_q.pins == `PINS_LMR;
   wire prea = cmd && s_q.pins == `PINS_PREA;

   // Controller cycles since reset and since the last command.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mck_n <= '0;
         gap <= '0;
         last_ref <= 1'b0;
      end
      else if (s_q.ph)
      begin
         if (mck_n != 8'hFF)
            mck_n <= 8'(mck_n + 8'h1);
         gap <= cmd ? 8'h1 : ((gap != 8'hFF) ? 8'(gap + 8'h1) : gap);
         if (cmd)
            last_ref <= (s_q.pins == `PINS_REF);
      end
   end

   sequence s_prea_soon;
      ##[1:4] prea;
   endsequence

   property p_mode_word;
      lmr && s_q.ba == `BA_MR |-> s_q.addr == MODE_WORD;
   endproperty
   a_mode_word: assert property (p_mode_word)
      else $error("Mode word differs from configuration.");

   property p_emr_skip;
      lmr && s_q.ba == `BA_EMR |-> DO_EMR && !s_q.done;
   endproperty
   a_emr_skip: assert property (p_emr_skip)
      else $error("Extended mode register written when disabled.");

   property p_prea_wait;
      prea && !s_q.done && DDR2 != 0 |-> mck_n > 8'(TCKP);
   endproperty
   a_prea_wait: assert property (p_prea_wait)
      else $error("Precharge-all came before the power-up wait.");

   property p_ref_gap;
      s_q.ph && cmd && last_ref |-> gap >= 8'(s_q.trfc);
   endproperty
   a_ref_gap: assert property (p_ref_gap)
      else $error("Command inside the refresh cycle time.");

   property p_burst_start;
      EXT_REF == 0 && s_q.en && s_q.st == S_IDLE && tif.done &&
         $rose(s_q.tally >= 4'(REF_BURST)) |-> s_prea_soon;
   endproperty
   a_burst_start: assert property (p_burst_start)
      else $error("Refresh burst did not start at the count.");

   property p_tally_clr;
      s_q.st == S_REF ##1 s_q.st == S_IDLE |-> s_q.tally <= 4'h1;
   endproperty
   a_tally_clr: assert property (p_tally_clr)
      else $error("Tally not cleared after the burst.");

   property p_odt;
      (mem_odt & ~ODT_MASK[SLOTS-1:0]) == '0;
   endproperty
   a_odt: assert property (p_odt)
      else $error("Termination driven outside its slots.");

   property p_clock;
      $past(rst_b) |-> mem_ck == ~$past(mem_ck);
   endproperty
   a_clock: assert property (p_clock)
      else $error("Memory clock failed to toggle.");

   property p_fixed;
      FIXED_TIMING != 0 |-> $stable(s_q.trefi) && $stable(s_q.trfc);
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("Fixed timing values changed.");

   property p_ext;
      EXT_REF != 0 && s_q.ext && s_q.en && s_q.st == S_IDLE && tif.done
         && s_q.ph |-> s_prea_soon;
   endproperty
   a_ext: assert property (p_ext)
      else $error("External refresh request not served.");

endmodule : ddr_init_refresh

/* verif/sdram_model.sv */
// Passive memory model that logs the commands issued by the controller.
`timescale 1ns/1ps
module sdram_model
   (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ck,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire logic [12:0] addr,
   output int n_prea,
   output int n_emr,
   output int n_ref,
   output logic [12:0] mode_word,
   output int min_gap
   );
   // ========================================================================
   // Command decode
   int gap;
   // Commands are taken where the memory clock is high, one memory clock
   // each, so back-to-back commands count one by one; gap is in those clocks.
   always @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
      begin
         {gap, n_prea, n_emr, n_ref} <= 128'h0;
         min_gap <= 32'hFFFF;
         mode_word <= 13'h0000;
      end
      else if (ck)
      begin
         gap <= gap + 1;
         if (!cs_n)
            case ({ras_n, cas_n, we_n})
               3'b010: if (addr[10]) n_prea <= n_prea + 1;
               3'b000: if (ba == 2'h0) mode_word <= addr;
                  else n_emr <= n_emr + 1;
               3'b001:
               begin
                  n_ref <= n_ref + 1;
                  gap <= 0;
                  if (n_ref > 0 && gap + 1 < min_gap)
                     min_gap <= gap + 1;
               end
               default: ;
            endcase
      end
endmodule : sdram_model

/* verif/ddr_init_refresh_bench.sv */
// Self-checking bench for the initialization and refresh sequencer.
`timescale 1ns/1ps
module ddr_init_refresh_bench;
   // ========================================================================
   // Stimulus and checking
   logic clk_sys = 0, rst_b = 0, rd = 0, wr = 0, xclk = 0, xreq = 0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wd = 32'h0, rdata, rdv;
   logic wreq, ras, cas, we, odt, done, cke;
   logic [1:0] ck, cs, ba, c0;
   logic [3:0] be = 4'hF;
   logic [12:0] ma, mw;
   int fails = 0, n_checks = 0, seed = 79;
   int np, ne, nr, gap, t, f, r0, p, k;
   // The burst count keeps its default, the largest allowed.
   ddr_init_refresh #(.CS_W(2), .CK_W(2), .BURST_LEN(8),
      .CAS_LAT(3), .BURST_ILV(1)) u_dut (.clk_sys(clk_sys),
      .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(wreq), .ext_ref_clk(xclk), .ext_ref_req(xreq),
      .mem_ck(ck), .mem_cke(cke), .mem_cs_n(cs), .mem_ras_n(ras),
      .mem_cas_n(cas), .mem_we_n(we), .mem_ba(ba), .mem_addr(ma),
      .mem_odt(odt), .init_done(done));
   sdram_model u_mem (.clk_sys(clk_sys), .rst_b(rst_b), .ck(ck[0]),
      .cs_n(cs[0]), .ras_n(ras), .cas_n(cas), .we_n(we), .ba(ba),
      .addr(ma),
      .n_prea(np), .n_emr(ne), .n_ref(nr), .mode_word(mw), .min_gap(gap));
   // Clocks: 200 MHz system clock and an unrelated 80 ns link clock.
   always #2.5 clk_sys = ~clk_sys;
   always #40 xclk = ~xclk;
   task check(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   // One bus access, held until waitrequest is sampled low.
   // Write data rides with the request, inside the user's allowance.
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      xreq <= 1'($random(seed));
      do @(posedge clk_sys); while (wreq !== 1'b0);
      rdv = rdata;
      wr <= 0;
      rd <= 0;
      @(posedge clk_sys);
   endtask : bus
   task rdchk(input logic [4:0] a, input logic [31:0] e);
      bus(0, a, 0);
      check(rdv, e);
   endtask : rdchk
   task wait_for(input int lim);
      k = 0;
      while (k < lim && (done !== 1'b1 || nr < r0)) @(posedge clk_sys) k++;
      if (k >= lim) fails++;
   endtask : wait_for
   // Mode word expected for a burst length, CAS latency and burst order.
   function automatic logic [31:0] mode_exp(input int bl, input int cl,
      input int ilv);
      mode_exp = (bl == 2) ? 1 : (bl == 4) ? 2 : 3;
      mode_exp = mode_exp | (ilv << 3) | (cl << 4);
   endfunction : mode_exp
   task wrap_up;
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // Main sequence of scenarios.
   initial
   begin
      repeat (4) @(posedge clk_sys);
      rst_b <= 1;
      rdchk(5'h18, 32'h08040A0D);
      rdchk(5'h14, mode_exp(8, 3, 1));
      rdchk(5'h0C, 32'h00000032);
      bus(1, 5'h1C, 32'hFFFFFFFF);
      rdchk(5'h1C, 32'h0);
      be <= 4'hE;
      bus(1, 5'h0C, 32'hFFFFFF00);
      be <= 4'hF;
      rdchk(5'h0C, 32'h00000032);
      r0 = 2;
      wait_for(5000);
      check({done, mw}, {1'b1, 13'(mode_exp(8, 3, 1))});
      check(np, 1);
      check(ne, 1);
      check(nr, 2);
      check({cs, cke}, 3'h7);
      c0 = ck;
      @(posedge clk_sys);
      check(ck, {2{~c0[0]}});
      t = 1 + {$random(seed)} % 14;
      f = 16 + {$random(seed)} % 16;
      bus(1, 5'h08, t);
      rdchk(5'h08, t);
      bus(1, 5'h04, f);
      rdchk(5'h04, f);
      p = np;
      r0 = nr + 8;
      wait_for(9000);
      repeat (20) @(posedge clk_sys);
      check(nr, r0);
      check(np, p + 1);
      check(gap, t);
      bus(0, 5'h10, 0);
      check(rdv[1:0], 2'b01);
      bus(1, 5'h00, 0);
      r0 = nr;
      repeat (32 * f + 600) @(posedge clk_sys);
      check(nr, r0);
      rdchk(5'h10, 32'h000000F1);
      bus(1, 5'h00, 1);
      r0 = nr + 8;
      wait_for(2000);
      check(nr, r0);
      check(odt, 0);
      wrap_up();
   end
   // Watchdog against a hung sequence.
   initial
   begin
      #150000;
      fails++;
      wrap_up();
   end
endmodule : ddr_init_refresh_bench
